//--- core/fro_defs.svh
// Constants for the file-register operation and call-through-working-register executor
`ifndef FRO_DEFS_SVH
`define FRO_DEFS_SVH
`define FRO_DATA_W 8
`define FRO_ADDR_W 7
`define FRO_PC_W 15
`define FRO_PC_LO_MSB 7
`define FRO_PC_HI_LSB 8
`define FRO_LATCH_HI_MSB 6
`define FRO_W_RESET 8'h00
`define FRO_Z_RESET 1'b0
`define FRO_PC_RESET 15'h0000
`define FRO_ZERO_BYTE 8'h00
`define FRO_ONE_BYTE 8'h01
`define FRO_ONE_PC 15'h0001
`define FRO_DEST_W 1'b0
`define FRO_DEST_F 1'b1
`endif

//--- core/fro_pkg.sv
// Types for the file-register operation and call-through-working-register executor
package fro_pkg;
    // Operation selected by the instruction decode ahead of this block
    typedef enum logic [2:0] {
        FRO_OP_NONE = 3'h0,
        FRO_OP_CALL_VIA_WORKING_REG = 3'h1,
        FRO_OP_COMPLEMENT_FILE = 3'h2,
        FRO_OP_CLEAR_FILE = 3'h3,
        FRO_OP_DECREMENT_FILE = 3'h4,
        FRO_OP_CLEAR_WORKING_REG = 3'h5,
        FRO_OP_DECREMENT_SKIP_ZERO = 3'h6,
        FRO_OP_INCREMENT_SKIP_ZERO = 3'h7
    } fro_op_type;

    // Executor phase: idle/first cycle, then second cycle of a two-cycle instruction
    typedef enum logic [1:0] {
        FRO_ST_EXEC = 2'b00,
        FRO_ST_SECOND = 2'b01
    } fro_state_type;

    // One issued instruction
    typedef struct packed {
        fro_op_type op;
        logic [6:0] file_addr;
        logic dest_f;
    } fro_instr_type;

    // File register write request
    typedef struct packed {
        logic en;
        logic [6:0] addr;
        logic [7:0] data;
    } fro_file_wr_type;

    // Return stack push request
    typedef struct packed {
        logic en;
        logic [14:0] addr;
    } fro_push_type;
endpackage : fro_pkg

//--- core/fro_exec.sv
// Executor for file-register single-operand ops, skip forms and call through working reg
// Functional notes
// - Call via working reg pushes next address onto return stack, flags untouched.
// - Call then loads working reg into counter 7:0, page latch 6:0 into 14:8.
// - Call via working reg takes two instruction cycles.
// - Complement inverts file, updates zero flag, dest 0 to working reg, 1 to file.
// - Clear file writes 00h to the file register and sets zero flag.
// - Decrement subtracts one, updates zero flag, dest selects working reg or file.
// - Clear working reg loads 00h into working reg and sets zero flag.
// - Decrement-skip subtracts one, routes result by dest, flags untouched.
// - Zero decrement-skip result discards next instruction, runs a no-op instead.
// - Increment-skip adds one, routes result by dest, flags untouched.
// - Zero increment-skip result replaces next instruction by no-op, two cycles.
`timescale 1ns/1ns
`include "fro_defs.svh"
////////////////////////////////////////////////////////////////////////////////
// Interface and timing notes
// Issue side:
// - The decoder offers one instruction per cycle on instr with instr_valid high.
// - An offer is taken on the rising edge where instr_valid is high and busy is low.
// - An offer made while busy is high is dropped without any indication.
// - The decoder must therefore hold off for one cycle after a call or a taken skip.
// Operand side:
// - file_rd_data is the content of instr.file_addr in the same cycle as the offer.
// - The data memory reads combinationally; this block adds no read latency.
// - The page latch is sampled only on the edge that takes a call.
// Answer timing:
// - Every effect of a taken instruction shows one cycle after the taking edge.
// - working_reg and zero_flag then stand until the next take; a taken skip moves program_counter once more.
// - file_wr.en and return_stack_push.en are one-cycle pulses.
// - file_wr.addr follows the operand every cycle; only the strobe gives it meaning.
// - busy and skip_next stand for exactly one cycle.
// Two-cycle forms:
// - A call always spends one extra cycle with busy high and skip_next low.
// - A skip whose result is zero spends one extra cycle with busy and skip_next high.
// - A skip with a nonzero result finishes in one cycle like any plain file op.
// Program counter model:
// - The counter advances by one for each instruction taken other than a call.
// - A skipped slot advances it once more, since that address is fetched and dropped.
// - A call jumps straight to its target and holds there through its second cycle.
// - The pushed return address is the counter plus one at the taking edge.
// Flag model:
// - Only complement, decrement, clear file and clear working reg touch the flag.
// - Call and both skip forms leave the flag as it was; loops rely on that.
// - Clear file ignores the destination select and always writes the file.
// Limitations:
// - Data bank selection is outside this block; the address is the 7-bit offset only.
// - The return stack depth and overflow are handled by the stack itself.
// - Other instructions of the set are decoded elsewhere and never reach this block.
// - Op code NONE only advances the counter; any idle cycle leaves working_reg and zero_flag untouched.
// Trade-offs:
// - All outputs are registered, which costs one cycle of answer latency.
// - In exchange the memory and stack see clean strobes with no decode glitches.
// - Skip decisions use the combinational result, so the operand path is the long one.
// Reset:
// - An asynchronous low on rst_n clears every output and the phase state.
// - The first instruction may be offered on the first edge after release.

module fro_exec #(
    parameter int DATA_W = `FRO_DATA_W,
    parameter int PC_W = `FRO_PC_W
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input fro_pkg::fro_instr_type instr,
    input wire logic [DATA_W-1:0] file_rd_data,
    input wire logic [6:0] program_page_latch,
    output fro_pkg::fro_file_wr_type file_wr,
    output fro_pkg::fro_push_type return_stack_push,
    output logic [PC_W-1:0] program_counter,
    output logic [DATA_W-1:0] working_reg,
    output logic zero_flag,
    output logic busy,
    output logic skip_next
);

    ////////////////////////////////////////////////////////////////////////////////
    // Registers behind the outputs
    fro_pkg::fro_file_wr_type file_wr_reg;
    fro_pkg::fro_push_type push_reg;
    logic [PC_W-1:0] pc_reg;
    logic [DATA_W-1:0] w_reg;
    logic z_reg;
    logic skip_reg;
    logic busy_reg;
    fro_pkg::fro_state_type state_reg;
    fro_pkg::fro_state_type state_next;

    ////////////////////////////////////////////////////////////////////////////////
    // Datapath
    logic take;
    logic [DATA_W-1:0] inc_val;
    logic [DATA_W-1:0] dec_val;
    logic [DATA_W-1:0] com_val;
    logic [PC_W-1:0] pc_plus_one;
    logic [PC_W-1:0] call_target;

    // An instruction is accepted only in the first phase; the decoder holds off while busy
    assign take = instr_valid && (state_reg == fro_pkg::FRO_ST_EXEC);
    assign inc_val = file_rd_data + `FRO_ONE_BYTE;
    assign dec_val = file_rd_data - `FRO_ONE_BYTE;
    // Complement is a per-bit inversion of the file operand
    genvar bit_idx;
    generate
        for (bit_idx = 0; bit_idx < DATA_W; bit_idx++) begin : g_com_bit
            assign com_val[bit_idx] = ~file_rd_data[bit_idx];
        end
    endgenerate
    assign pc_plus_one = pc_reg + `FRO_ONE_PC;
    // Low byte from working reg, high bits from page latch
    assign call_target = {program_page_latch[`FRO_LATCH_HI_MSB:0], w_reg};

    ////////////////////////////////////////////////////////////////////////////////
    // Phase sequencing: second cycle for the call and for a taken skip
    always_comb begin
        state_next = fro_pkg::FRO_ST_EXEC;
        if (take) begin
            case (instr.op)
                fro_pkg::FRO_OP_CALL_VIA_WORKING_REG: begin
                    state_next = fro_pkg::FRO_ST_SECOND;
                end
                fro_pkg::FRO_OP_DECREMENT_SKIP_ZERO: begin
                    if (dec_val == `FRO_ZERO_BYTE) begin
                        state_next = fro_pkg::FRO_ST_SECOND;
                    end
                end
                fro_pkg::FRO_OP_INCREMENT_SKIP_ZERO: begin
                    if (inc_val == `FRO_ZERO_BYTE) begin
                        state_next = fro_pkg::FRO_ST_SECOND;
                    end
                end
                default: begin
                    state_next = fro_pkg::FRO_ST_EXEC;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= fro_pkg::FRO_ST_EXEC;
        end else begin
            state_reg <= state_next;
        end
    end

    // Busy registered on its own so the port comes straight from a flip-flop
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= (state_next == fro_pkg::FRO_ST_SECOND);
        end
    end

    // Busy flags the second cycle; skip marks it as the no-op that replaces a fetch
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            skip_reg <= 1'b0;
        end else begin
            skip_reg <= take && (state_next == fro_pkg::FRO_ST_SECOND)
                && (instr.op != fro_pkg::FRO_OP_CALL_VIA_WORKING_REG);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Program counter: advance per instruction, jump on the call
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_reg <= `FRO_PC_RESET;
        end else if (take && instr.op == fro_pkg::FRO_OP_CALL_VIA_WORKING_REG) begin
            pc_reg <= call_target;
        end else if (take || state_reg == fro_pkg::FRO_ST_SECOND) begin
            // Skipped slot still consumes the discarded address
            pc_reg <= (state_reg == fro_pkg::FRO_ST_SECOND && !skip_reg) ? pc_reg
                : pc_plus_one;
        end
    end

    // Return address pushed in the same cycle the call is taken
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            push_reg <= '0;
        end else begin
            push_reg.en <= take && instr.op == fro_pkg::FRO_OP_CALL_VIA_WORKING_REG;
            push_reg.addr <= pc_plus_one;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Working register: written by clear working reg and by file ops aimed at it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            w_reg <= `FRO_W_RESET;
        end else if (take) begin
            case (instr.op)
                fro_pkg::FRO_OP_COMPLEMENT_FILE: begin
                    if (instr.dest_f == `FRO_DEST_W) begin
                        w_reg <= com_val;
                    end
                end
                fro_pkg::FRO_OP_DECREMENT_FILE,
                fro_pkg::FRO_OP_DECREMENT_SKIP_ZERO: begin
                    if (instr.dest_f == `FRO_DEST_W) begin
                        w_reg <= dec_val;
                    end
                end
                fro_pkg::FRO_OP_INCREMENT_SKIP_ZERO: begin
                    if (instr.dest_f == `FRO_DEST_W) begin
                        w_reg <= inc_val;
                    end
                end
                fro_pkg::FRO_OP_CLEAR_WORKING_REG: begin
                    w_reg <= `FRO_ZERO_BYTE;
                end
                default: begin
                    w_reg <= w_reg;
                end
            endcase
        end
    end

    // File write: one-cycle strobe; address tracks the operand so no extra mux is needed
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            file_wr_reg <= '0;
        end else begin
            file_wr_reg.en <= 1'b0;
            file_wr_reg.addr <= instr.file_addr;
            if (take) begin
                case (instr.op)
                    fro_pkg::FRO_OP_COMPLEMENT_FILE: begin
                        if (instr.dest_f == `FRO_DEST_F) begin
                            file_wr_reg.en <= 1'b1;
                            file_wr_reg.data <= com_val;
                        end
                    end
                    fro_pkg::FRO_OP_CLEAR_FILE: begin
                        file_wr_reg.en <= 1'b1;
                        file_wr_reg.data <= `FRO_ZERO_BYTE;
                    end
                    fro_pkg::FRO_OP_DECREMENT_FILE,
                    fro_pkg::FRO_OP_DECREMENT_SKIP_ZERO: begin
                        if (instr.dest_f == `FRO_DEST_F) begin
                            file_wr_reg.en <= 1'b1;
                            file_wr_reg.data <= dec_val;
                        end
                    end
                    fro_pkg::FRO_OP_INCREMENT_SKIP_ZERO: begin
                        if (instr.dest_f == `FRO_DEST_F) begin
                            file_wr_reg.en <= 1'b1;
                            file_wr_reg.data <= inc_val;
                        end
                    end
                    default: begin
                        file_wr_reg.en <= 1'b0;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Zero flag: only the plain file ops and clear working reg touch it; call and skip forms leave it alone
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            z_reg <= `FRO_Z_RESET;
        end else if (take) begin
            case (instr.op)
                fro_pkg::FRO_OP_COMPLEMENT_FILE: begin
                    z_reg <= (com_val == `FRO_ZERO_BYTE);
                end
                fro_pkg::FRO_OP_DECREMENT_FILE: begin
                    z_reg <= (dec_val == `FRO_ZERO_BYTE);
                end
                fro_pkg::FRO_OP_CLEAR_FILE,
                fro_pkg::FRO_OP_CLEAR_WORKING_REG: begin
                    z_reg <= 1'b1;
                end
                default: begin
                    z_reg <= z_reg;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops
    assign file_wr = file_wr_reg;
    assign return_stack_push = push_reg;
    assign program_counter = pc_reg;
    assign working_reg = w_reg;
    assign zero_flag = z_reg;
    assign busy = busy_reg;
    assign skip_next = skip_reg;

endmodule : fro_exec

//--- bench/fro_exec_sva.sv
// Assertion checker for the file-register executor ports
`timescale 1ns/1ns
module fro_exec_sva #(
    parameter int DATA_W = 8,
    parameter int PC_W = 15
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input fro_pkg::fro_instr_type instr,
    input wire logic [DATA_W-1:0] file_rd_data,
    input wire logic [6:0] program_page_latch,
    input fro_pkg::fro_file_wr_type file_wr,
    input fro_pkg::fro_push_type return_stack_push,
    input wire logic [PC_W-1:0] program_counter,
    input wire logic [DATA_W-1:0] working_reg,
    input wire logic zero_flag,
    input wire logic busy,
    input wire logic skip_next
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic tk;
    logic [2:0] op;
    // A request offered while busy is dropped, so only count real takes
    assign tk = instr_valid && !busy;
    assign op = instr.op;
    ////////////////////////////////////////////////////////////////////////////
    // Properties
    call_push_a: assert property (tk && op == 3'h1 |=> return_stack_push.en &&
        return_stack_push.addr == $past(program_counter) + 15'h1) else $error("bad push");
    call_pc_a: assert property (tk && op == 3'h1 |=> program_counter ==
        {$past(program_page_latch), $past(working_reg)}) else $error("bad call target");
    call_busy_a: assert property (tk && op == 3'h1 |=> busy ##1 !busy)
        else $error("call length wrong");
    complement_file_w_a: assert property (tk && op == 3'h2 && !instr.dest_f |=>
        working_reg == ~$past(file_rd_data) && zero_flag == (working_reg == 8'h00))
        else $error("bad complement");
    clear_file_a: assert property (tk && op == 3'h3 |=> file_wr.en &&
        file_wr.data == 8'h00 && zero_flag) else $error("bad clear file");
    decrement_file_f_a: assert property (tk && op == 3'h4 && instr.dest_f |=> file_wr.en &&
        file_wr.data == $past(file_rd_data) - 8'h1) else $error("bad decrement");
    clear_working_reg_a: assert property (tk && op == 3'h5 |=> working_reg == 8'h00 && zero_flag)
        else $error("bad clear working");
    keep_flag_a: assert property (tk && (op == 3'h1 || op >= 3'h6) |=>
        $stable(zero_flag)) else $error("flag moved");
    dec_skip_a: assert property (tk && op == 3'h6 && file_rd_data == 8'h01 |=>
        skip_next && busy ##1 !busy) else $error("skip missing");
    inc_skip_a: assert property (tk && op == 3'h7 && file_rd_data != 8'hff |=>
        !skip_next && !busy) else $error("false skip");
endmodule : fro_exec_sva

//--- bench/tb.sv
// Self-checking testbench for the file-register executor
`timescale 1ns/1ns
module tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic instr_valid = 1'b0;
    fro_pkg::fro_instr_type instr = '0;
    logic [7:0] file_rd_data = 8'h00;
    logic [6:0] program_page_latch = 7'h55;
    fro_pkg::fro_file_wr_type file_wr;
    fro_pkg::fro_push_type return_stack_push;
    logic [14:0] program_counter;
    logic [14:0] pc0;
    logic [7:0] working_reg;
    logic zero_flag;
    logic busy;
    logic skip_next;
    int err_total = 0;
    int n_checks = 0;
    // 50 ns clock
    always #25 ref_clk = ~ref_clk;
    fro_exec #(.DATA_W(8), .PC_W(15)) i_dut (.ref_clk, .rst_n, .instr_valid, .instr,
        .file_rd_data, .program_page_latch, .file_wr, .return_stack_push,
        .program_counter, .working_reg, .zero_flag, .busy, .skip_next);
    ////////////////////////////////////////////////////////////////////////////
    // Compare helpers
    task automatic chk_v(input string n, input logic [14:0] e, input logic [14:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask : chk_v
    task automatic chk_b(input string n, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s exp %b got %b", n, e, g);
        end
    endtask : chk_b
    // One idle edge before each offer keeps two-cycle ops legal
    task automatic issue(input logic [2:0] op, input logic d, input logic [7:0] rd);
        @(posedge ref_clk);
        instr_valid <= 1'b1;
        instr <= '{fro_pkg::fro_op_type'(op), 7'h7f, d};
        file_rd_data <= rd;
        #1 pc0 = program_counter;
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        #1;
    endtask : issue
    task automatic res(input logic d, input logic [7:0] e);
        chk_b("wr_en", d, file_wr.en);
        if (d) chk_v("wr_data", e, file_wr.data);
        else chk_v("w", e, working_reg);
    endtask : res
    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_complement_file;
        issue(3'h2, 1'b1, 8'hff);
        res(1'b1, 8'h00);
        chk_v("addr", 15'h7f, file_wr.addr);
        chk_b("z", 1'b1, zero_flag);
        issue(3'h2, 1'b0, 8'h5a);
        res(1'b0, 8'ha5);
        chk_b("z", 1'b0, zero_flag);
        $display("complement done");
    endtask : t_complement_file
    task automatic t_call;
        issue(3'h1, 1'b0, 8'h00);
        chk_b("push", 1'b1, return_stack_push.en);
        chk_v("ret", pc0 + 15'h1, return_stack_push.addr);
        chk_v("pc", {7'h55, 8'ha5}, program_counter);
        chk_b("z", 1'b0, zero_flag);
        chk_b("busy", 1'b1, busy);
        @(posedge ref_clk);
        #1 chk_b("busy", 1'b0, busy);
        $display("call done");
    endtask : t_call
    task automatic t_clr;
        issue(3'h3, 1'b0, 8'h33);
        res(1'b1, 8'h00);
        chk_b("z", 1'b1, zero_flag);
        issue(3'h4, 1'b1, 8'h00);
        res(1'b1, 8'hff);
        chk_b("z", 1'b0, zero_flag);
        issue(3'h5, 1'b0, 8'h12);
        res(1'b0, 8'h00);
        chk_b("z", 1'b1, zero_flag);
        $display("clear done");
    endtask : t_clr
    task automatic t_skip(input logic [2:0] op, input logic d, input logic [7:0] rd, e,
        input logic sk);
        logic z0;
        z0 = zero_flag;
        issue(op, d, rd);
        res(d, e);
        chk_b("z", z0, zero_flag);
        chk_b("skip", sk, skip_next);
        chk_b("busy", sk, busy);
        @(posedge ref_clk);
        #1 chk_v("pc", pc0 + (sk ? 15'h2 : 15'h1), program_counter);
        $display("skip case done");
    endtask : t_skip
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test
    // Main sequence
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_complement_file();
        t_call();
        t_clr();
        t_skip(3'h6, 1'b1, 8'h01, 8'h00, 1'b1);
        issue(3'h4, 1'b0, 8'h81);
        res(1'b0, 8'h80);
        t_skip(3'h6, 1'b0, 8'h00, 8'hff, 1'b0);
        t_skip(3'h7, 1'b0, 8'hff, 8'h00, 1'b1);
        t_skip(3'h7, 1'b1, 8'h7f, 8'h80, 1'b0);
        end_of_test();
    end
    // Watchdog, far beyond the roughly 40 cycles the tests need
    initial begin
        #(4000 * 50);
        err_total++;
        end_of_test();
    end
endmodule : tb
bind fro_exec fro_exec_sva #(.DATA_W(DATA_W), .PC_W(PC_W)) i_sva (.ref_clk, .rst_n,
    .instr_valid, .instr, .file_rd_data, .program_page_latch, .file_wr,
    .return_stack_push, .program_counter, .working_reg, .zero_flag, .busy, .skip_next);
